// ---- core/mis_pkg.sv ----
package mis_pkg;
  // Microprogram address geometry: row part and column part
  localparam int ROW_W = 5;
  localparam int COL_W = 4;
  localparam int OP_W = 3;
  localparam int ADDR_W = ROW_W + COL_W;
  localparam int NUM_REQ_DEF = 8;
  // Next-address opcodes
  localparam logic [OP_W-1:0] OP_JZR = 3'h0;
  localparam logic [OP_W-1:0] OP_JCR = 3'h1;
  localparam logic [OP_W-1:0] OP_INC = 3'h2;
  // Operand of the jump that strobes the interrupt unit
  localparam logic [COL_W-1:0] IRQ_COL = 4'hF;
  // Row that the pull-ups or the multiplexer present during an interrupt
  localparam logic [ROW_W-1:0] ROW_PULLED = 5'h1F;
  localparam logic [ROW_W-1:0] ROW_ZERO = 5'h00;
  localparam logic [COL_W-1:0] COL_ONE = 4'h1;
  localparam logic [ADDR_W-1:0] ADDR_RST = 9'h000;

  // How the acknowledge redirects the next microinstruction
  typedef enum logic [1:0] {
    MIS_SCH_TRISTATE,
    MIS_SCH_MUX,
    MIS_SCH_CTLBIT
  } mis_scheme_t;

  typedef struct packed {
    logic [OP_W-1:0] op;
    logic [COL_W-1:0] operand;
  } mis_ctl_t;

  typedef struct packed {
    logic [ROW_W-1:0] row;
    logic [COL_W-1:0] col;
  } mis_addr_t;
endpackage

// ---- core/mis_irq_unit.sv ----
`timescale 1ns/10ps
`default_nettype none
module mis_irq_unit import mis_pkg::*; #(
  parameter int NUM_REQ = NUM_REQ_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic strobe,
  input wire logic [NUM_REQ-1:0] irq_req,
  output logic irq_ack_n,
  output logic [$clog2(NUM_REQ)-1:0] irq_level
);
  localparam int LVL_W = $clog2(NUM_REQ);

  // Elaboration check: the level output cannot encode other request counts
  if (NUM_REQ < 2 || NUM_REQ > 16) begin : g_num_req_check
    $error("mis_irq_unit: NUM_REQ must lie in 2..16");
  end

  logic ack;
  logic next_ack;
  logic [LVL_W-1:0] next_level;
  logic [LVL_W-1:0] prio;

  // Highest numbered pending request wins
  always_comb begin
    prio = '0;
    for (int i = 0; i < NUM_REQ; i++) begin
      if (irq_req[i]) begin
        prio = LVL_W'(i);
      end
    end
  end

  // Acknowledge is taken only at a strobed edge with a request pending
  always_comb begin
    next_ack = strobe && (|irq_req);
    next_level = next_ack ? prio : irq_level;
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      ack <= 1'b0;
      irq_level <= '0;
    end else begin
      ack <= next_ack;
      irq_level <= next_level;
    end
  end

  assign irq_ack_n = ~ack;
endmodule
`default_nettype wire

// ---- core/mis_sequencer.sv ----
`timescale 1ns/10ps
`default_nettype none
module mis_sequencer import mis_pkg::*; #(
  parameter int NUM_REQ = NUM_REQ_DEF
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire mis_scheme_t scheme,
  input wire mis_ctl_t next_addr_control,
  input wire logic ctl_strobe_bit,
  input wire logic [NUM_REQ-1:0] irq_req,
  output mis_addr_t mem_addr,
  output logic [ROW_W-1:0] row_address_outputs,
  output logic row_address_oe,
  output logic interrupt_strobe_out,
  output logic irq_ack_n,
  output logic [$clog2(NUM_REQ)-1:0] irq_level,
  output logic extend_cycle
);
  localparam int LVL_W = $clog2(NUM_REQ);

  // Priority encoder and level output are only sized for this many requests
  if (NUM_REQ < 2 || NUM_REQ > 16) begin : g_num_req_check
    $error("mis_sequencer: NUM_REQ must lie in 2..16");
  end

  // Holding register, the field as the sequencer uses it, and local strobes
  mis_addr_t addr;
  mis_addr_t next_addr;
  mis_ctl_t eff_ctl;
  logic ack;
  logic row_output_enable;
  logic jzr15;
  logic unit_strobe;

  // Acknowledge as an active-high level for the local logic
  assign ack = ~irq_ack_n;

  // Acknowledge reaches the row enable only in the tri-state scheme
  assign row_output_enable = (scheme == MIS_SCH_TRISTATE) ? irq_ack_n : 1'b1;

  // Row pins: driver floats while the enable is low
  assign row_address_outputs = addr.row;
  assign row_address_oe = row_output_enable;

  // Address seen by the memory; pull-ups or the mux give all ones
  always_comb begin
    mem_addr = addr;
    if (ack && scheme != MIS_SCH_CTLBIT) begin
      mem_addr.row = ROW_PULLED;
    end
  end

  // Control field taken combinationally; the control-bit scheme clears its low bit
  always_comb begin
    eff_ctl = next_addr_control;
    if (ack && scheme == MIS_SCH_CTLBIT) begin
      eff_ctl.operand[0] = 1'b0;
    end
  end

  // Strobe decode; the interrupt cycle itself is kept from strobing again
  always_comb begin
    jzr15 = (eff_ctl.op == OP_JZR) && (eff_ctl.operand == IRQ_COL);
    interrupt_strobe_out = jzr15 && !ack;
  end

  // The own strobe comes a cycle too late for the control-bit scheme, so the ROM bit drives it there
  assign unit_strobe = (scheme == MIS_SCH_CTLBIT) ? ctl_strobe_bit : interrupt_strobe_out;

  // Stretch request to the clock generator lasts for the interrupt cycle only
  assign extend_cycle = ack;

  // Next address from the effective control field and the address the memory saw
  always_comb begin
    next_addr = mem_addr;
    case (eff_ctl.op)
      OP_JZR: begin
        next_addr.row = ROW_ZERO;
        next_addr.col = eff_ctl.operand;
      end
      OP_JCR: begin
        next_addr.col = eff_ctl.operand;
      end
      OP_INC: begin
        next_addr.col = mem_addr.col + COL_ONE;
      end
      default: begin
        next_addr = mem_addr;
      end
    endcase
  end

  // Holding register, loaded on every edge
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      addr <= ADDR_RST;
    end else begin
      addr <= next_addr;
    end
  end

  // Interrupt unit: acknowledge register and the level of the winning request
  mis_irq_unit #(
    .NUM_REQ(NUM_REQ)
  ) u_irq (
    .clk_sys(clk_sys),
    .rst(rst),
    .strobe(unit_strobe),
    .irq_req(irq_req),
    .irq_ack_n(irq_ack_n),
    .irq_level(irq_level)
  );

  // Checks sample on the system clock and sleep through reset
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (rst);

  // Address path: every edge loads what the effective field selects
  addr_jzr_load_a: assert property (
    (eff_ctl.op == OP_JZR) |=> (addr.row == ROW_ZERO) && (addr.col == $past(eff_ctl.operand))
  ) else $error("holding register missed a zero-row jump");

  addr_jcr_load_a: assert property (
    (eff_ctl.op == OP_JCR) |=> (addr.row == $past(mem_addr.row)) && (addr.col == $past(eff_ctl.operand))
  ) else $error("same-row jump did not load the field column");

  addr_inc_a: assert property (
    (eff_ctl.op == OP_INC) |=> (addr.row == $past(mem_addr.row)) && (addr.col == $past(mem_addr.col) + COL_ONE)
  ) else $error("column increment not loaded");

  addr_hold_a: assert property (
    (eff_ctl.op != OP_JZR && eff_ctl.op != OP_JCR && eff_ctl.op != OP_INC) |=> (addr == $past(mem_addr))
  ) else $error("unused opcode moved the address");

  row_pins_a: assert property (
    row_address_outputs == addr.row
  ) else $error("row pins differ from the holding register");

  // Interrupt path: strobe, acknowledge and level
  strobe_decode_a: assert property (
    (next_addr_control.op == OP_JZR && next_addr_control.operand == IRQ_COL && !ack)
      |-> interrupt_strobe_out
  ) else $error("jump to column 15 gave no strobe");

  ack_set_a: assert property (
    (unit_strobe && (|irq_req)) |=> !irq_ack_n
  ) else $error("pending request not acknowledged");

  ack_idle_a: assert property (
    !(unit_strobe && (|irq_req)) |=> irq_ack_n
  ) else $error("acknowledge without strobe and request");

  level_hold_a: assert property (
    !(unit_strobe && (|irq_req)) |=> $stable(irq_level)
  ) else $error("level changed without an acknowledge");

  level_take_a: assert property (
    (unit_strobe && irq_req[NUM_REQ-1]) |=> (irq_level == LVL_W'(NUM_REQ - 1))
  ) else $error("top request did not win the priority");

  extend_match_a: assert property (
    extend_cycle == !irq_ack_n
  ) else $error("stretch request out of step with acknowledge");

  row_float_a: assert property (
    (scheme == MIS_SCH_TRISTATE && ack) |-> !row_address_oe && (mem_addr.row == ROW_PULLED)
  ) else $error("row outputs driven during acknowledge");

  no_restrobe_a: assert property (
    ack |-> !interrupt_strobe_out
  ) else $error("interrupt cycle strobed again");

  ack_single_a: assert property (
    (ack && scheme != MIS_SCH_CTLBIT) |=> irq_ack_n
  ) else $error("acknowledge held past the interrupt cycle");

  // Row handling per scheme
  mux_row_a: assert property (
    (scheme == MIS_SCH_MUX && ack) |-> row_address_oe && (mem_addr.row == ROW_PULLED)
  ) else $error("mux scheme row not all ones");

  oe_idle_a: assert property (
    irq_ack_n |-> row_address_oe && (mem_addr == addr)
  ) else $error("row outputs disabled outside acknowledge");

  ctl_row_kept_a: assert property (
    (scheme == MIS_SCH_CTLBIT && ack) |-> row_address_oe && (mem_addr == addr)
  ) else $error("control-bit scheme touched the row outputs");

  ctl_no_strobe_a: assert property (
    (scheme == MIS_SCH_CTLBIT && ack && next_addr_control.op == OP_JZR && next_addr_control.operand == IRQ_COL)
      |-> !interrupt_strobe_out && (eff_ctl.operand[0] == 1'b0)
  ) else $error("modified field still decoded as the strobe jump");

  ctlbit_jump_a: assert property (
    (scheme == MIS_SCH_CTLBIT && ctl_strobe_bit && (|irq_req)) ##1
      (scheme == MIS_SCH_CTLBIT && next_addr_control.op == OP_JZR && next_addr_control.operand == IRQ_COL)
      |=> (addr.row == ROW_ZERO) && (addr.col == {IRQ_COL[COL_W-1:1], 1'b0})
  ) else $error("control-bit scheme missed the interrupt jump");

  // Main scenarios: one acknowledge per scheme, an idle strobe and a modified jump
  irq_tristate_c: cover property (scheme == MIS_SCH_TRISTATE && interrupt_strobe_out && (|irq_req) ##1 ack);
  irq_mux_c: cover property (scheme == MIS_SCH_MUX && interrupt_strobe_out && (|irq_req) ##1 ack);
  irq_ctlbit_c: cover property (scheme == MIS_SCH_CTLBIT && ctl_strobe_bit && (|irq_req) ##1 ack);
  strobe_no_req_c: cover property (interrupt_strobe_out && !(|irq_req));
  ctl_wait_jump_c: cover property (scheme == MIS_SCH_CTLBIT && ack && eff_ctl.op == OP_JZR);
endmodule
`default_nettype wire

// ---- bench/mis_rom_model.sv ----
`timescale 1ns/10ps
`default_nettype none
module mis_rom_model import mis_pkg::*; (
  input wire mis_addr_t mem_addr,
  output mis_ctl_t next_addr_control,
  output logic ctl_strobe_bit
);
  // Word is {strobe bit, op, operand}; unwritten words hold the address
  logic [7:0] word [0:(1<<ADDR_W)-1];
  initial begin
    for (int i = 0; i < (1 << ADDR_W); i++) begin
      word[i] = 8'h30;
    end
  end
  // No pipeline stage: the word follows the address at once
  assign {ctl_strobe_bit, next_addr_control} = word[mem_addr];
endmodule
`default_nettype wire

// ---- bench/tb_top.sv ----
`timescale 1ns/10ps
`default_nettype none
module tb_top import mis_pkg::*;;
  logic clk_sys, rst, sbit, oe, strobe, ack_n, ext;
  mis_scheme_t scheme;
  mis_ctl_t nac;
  logic [7:0] irq_req;
  mis_addr_t mem_addr;
  logic [ROW_W-1:0] row_out;
  logic [2:0] irq_level;
  int error_cnt, compares, cyc;
  mis_sequencer #(.NUM_REQ(8)) dut(.clk_sys(clk_sys), .rst(rst), .scheme(scheme),
    .next_addr_control(nac), .ctl_strobe_bit(sbit), .irq_req(irq_req), .mem_addr(mem_addr),
    .row_address_outputs(row_out), .row_address_oe(oe), .interrupt_strobe_out(strobe),
    .irq_ack_n(ack_n), .irq_level(irq_level), .extend_cycle(ext));
  mis_rom_model rom(.mem_addr(mem_addr), .next_addr_control(nac), .ctl_strobe_bit(sbit));
  // Inputs move 1 ns after the edge so no race with the design
  task automatic step();
    @(posedge clk_sys);
    #1;
  endtask
  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    compares++;
    if (got !== exp) begin
      error_cnt++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic restart(input mis_scheme_t s, input logic [7:0] req);
    scheme = s;
    irq_req = req;
    rst = 1'b1;
    step();
    rst = 1'b0;
    chk("addr after reset", 9'h000, mem_addr);
  endtask
  // Plain sequencing, then a strobe with nothing pending
  task automatic t_seq();
    rom.word[9'h000] = 8'h05;
    rom.word[9'h005] = 8'h19;
    rom.word[9'h009] = 8'h20;
    rom.word[9'h00A] = 8'h0F;
    restart(MIS_SCH_TRISTATE, 8'h00);
    step();
    chk("jzr addr", 9'h005, mem_addr);
    step();
    chk("jcr addr", 9'h009, mem_addr);
    step();
    chk("inc addr", 9'h00A, mem_addr);
    chk("strobe", 9'h001, strobe);
    step();
    chk("no ack", 9'h001, ack_n);
    chk("addr 0F", 9'h00F, mem_addr);
  endtask
  // Acknowledge via floating row outputs or the multiplexer
  task automatic t_irq(input mis_scheme_t s);
    rom.word[9'h000] = 8'h0F;
    rom.word[9'h1FF] = 8'h0F;
    restart(s, 8'h24);
    chk("strobe c0", 9'h001, strobe);
    step();
    chk("ack", 9'h000, ack_n);
    chk("extend", 9'h001, ext);
    chk("row oe", {8'h00, s != MIS_SCH_TRISTATE}, oe);
    chk("irq addr", 9'h1FF, mem_addr);
    chk("row pins", 9'h000, row_out);
    chk("no restrobe", 9'h000, strobe);
    step();
    chk("ack ends", 9'h001, ack_n);
    chk("after irq", 9'h00F, mem_addr);
    chk("level", 9'h005, irq_level);
  endtask
  // Acknowledge clears the low control bit; strobe from a wait word
  task automatic t_ctl();
    rom.word[9'h000] = 8'h83;
    rom.word[9'h003] = 8'h0F;
    restart(MIS_SCH_CTLBIT, 8'h80);
    step();
    chk("ctl ack", 9'h000, ack_n);
    chk("row kept", 9'h003, mem_addr);
    chk("oe kept", 9'h001, oe);
    step();
    chk("jump 0E", 9'h00E, mem_addr);
    chk("ack once", 9'h001, ack_n);
    chk("ctl level", 9'h007, irq_level);
  endtask
  task automatic test_done();
    $display("comparisons %0d mismatches %0d", compares, error_cnt);
    if (error_cnt == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  // Hang guard: the whole run needs well under a hundred cycles
  always @(posedge clk_sys) begin
    cyc++;
    if (cyc > 2000) begin
      error_cnt++;
      test_done();
    end
  end
  initial begin
    rst = 1'b1;
    scheme = MIS_SCH_TRISTATE;
    irq_req = 8'h00;
    repeat (8) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_seq();
    t_irq(MIS_SCH_TRISTATE);
    t_irq(MIS_SCH_MUX);
    t_ctl();
    test_done();
  end
endmodule
`default_nettype wire
